// file: logic/scc_channel.v
/*
  Serial channel with UART and clocked I/O modes, flow control, buffer,
  double buffer and FIFO interrupt timing, error flags, two-write soft
  reset and DMA requests, behind a classic Wishbone slave.
  Assumes rxd, cts_n and sclk are asynchronous pins and that the baud
  generator is reduced to a fixed divider of mclk.
*/
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "scc_defines.vh"

module scc_channel #(
  parameter       AW  = 2,      // Log2 of the FIFO depth.
  parameter [7:0] DIV = 8'h04   // Serial tick divider of mclk.
) (
  input  wire        mclk,        // System clock.
  input  wire        rstn,        // Asynchronous reset, active low.
  input  wire        ce,          // Clock enable, freezes all state when low.
  input  wire        wb_cyc_i,    // Wishbone cycle.
  input  wire        wb_stb_i,    // Wishbone strobe.
  input  wire        wb_we_i,     // Wishbone write enable.
  input  wire [7:0]  wb_adr_i,    // Wishbone byte address.
  input  wire [3:0]  wb_sel_i,    // Wishbone byte selects.
  input  wire [31:0] wb_dat_i,    // Wishbone write data.
  output reg  [31:0] wb_dat_o,    // Wishbone read data.
  output reg         wb_ack_o,    // Wishbone acknowledge.
  input  wire        rxd,         // Serial receive pin.
  input  wire        cts_n,       // Clear to send, high holds transmission.
  input  wire        sclk,        // Shift clock input in clocked mode.
  output reg         txd,         // Serial transmit pin.
  output reg         rx_irq,      // Receive interrupt pulse.
  output reg         tx_irq,      // Transmit interrupt pulse.
  output reg         rx_dma_req,  // Receive DMA request pulse.
  output reg         tx_dma_req   // Transmit DMA request pulse.
);
  localparam QD = 1 << AW;
  localparam [AW:0] CAPF = QD[AW:0];
  localparam [AW:0] ONE  = {{AW{1'b0}}, 1'b1};

  wire [2:0] pin_s;
  scc_sync #(.W(3)) u_sync (
    .mclk (mclk),
    .rstn (rstn),
    .ce   (ce),
    .d    ({sclk, cts_n, rxd}),
    .q    (pin_s)
  );
  wire rxd_s  = pin_s[0];
  wire cts_s  = pin_s[1];
  wire sclk_s = pin_s[2];

  reg [7:0]  ctrl_q, mode0_q, mode2_q, rfc_q, tfc_q, dma_q;
  reg        tx_en_q, sw_arm_q;
  reg        ovr_q, par_q, frm_q, rx9_q;
  reg        sclk_prev_q, rxd_prev_q;
  reg [7:0]  div_q;
  reg [3:0]  tx_cnt16_q, rx_cnt16_q;
  reg [7:0]  txq [0:QD-1];
  reg [7:0]  rxq [0:QD-1];
  reg [AW-1:0] tx_rd_q, rx_rd_q;
  reg [AW:0] tx_cnt_q, rx_cnt_q;
  reg [10:0] tx_sh_q;
  reg [3:0]  tx_bits_q, rx_bit_q;
  reg        tx_full_q, tx_busy_q, tx_sent_q;
  reg [8:0]  rx_sh_q;
  reg        rx_busy_q, rx_pend_q;
  reg [7:0]  rx_pend_w_q;
  reg        tx_chk_q, rx_chk_q;

  wire uart   = ~mode0_q[`SCC_M0_IO];
  wire io     = mode0_q[`SCC_M0_IO];
  wire rx_en  = mode0_q[`SCC_M0_RXEN];
  wire fifo   = mode2_q[`SCC_M2_FIFO];
  wire dbl    = mode2_q[`SCC_M2_DBL] & ~fifo;
  wire sgl    = ~mode2_q[`SCC_M2_DBL] & ~fifo;
  wire ckout  = ctrl_q[`SCC_CTRL_CKOUT];
  wire extra  = mode0_q[`SCC_M0_NINE] | mode0_q[`SCC_M0_PAREN];
  wire [AW:0] cap = fifo ? CAPF : ONE;

  // Bus decode; side effects happen at the edge that raises the acknowledge.
  wire acc    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr     = acc & wb_we_i & wb_sel_i[0];
  wire rd     = acc & ~wb_we_i;
  wire a_data = (wb_adr_i == `SCC_OFS_DATA);
  wire a_ctrl = (wb_adr_i == `SCC_OFS_CTRL);
  wire a_m2   = (wb_adr_i == `SCC_OFS_MODE2);
  wire [7:0] wd = wb_dat_i[7:0];

  wire swr     = wr & a_m2 & sw_arm_q & (wd[3:2] == `SCC_SOFT_RESET_FIELD_SECOND);
  wire tx_push = wr & a_data & (tx_cnt_q != cap);
  wire rx_pop  = rd & a_data & (rx_cnt_q != {(AW+1){1'b0}});
  wire flg_clr = rd & a_ctrl;

  // Serial tick and transmit bit clock.
  wire tick = (div_q == DIV - 8'h01);
  wire tbc  = tick & (tx_cnt16_q == `SCC_TBC_LAST);

  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire io_edge   = io & (ctrl_q[`SCC_CTRL_EDGE] ? sclk_rise : sclk_fall);

  // Transmit path.
  wire hold     = mode0_q[`SCC_M0_FLOW] & cts_s;
  wire tx_load  = tx_en_q & ~tx_full_q & (tx_cnt_q != {(AW+1){1'b0}});
  wire tx_adv_u = tbc & uart & tx_full_q & (tx_busy_q | ~hold);
  wire tx_fin_u = tx_adv_u & tx_busy_q & (tx_bits_q == 4'h0);
  wire tx_adv_i = io_edge & tx_en_q & tx_full_q;
  wire tx_fin_i = tx_adv_i & (tx_bits_q == 4'h1);
  wire tx_fin   = tx_fin_u | tx_fin_i;
  wire tx_und   = io_edge & tx_en_q & ~tx_full_q & tx_sent_q & ~ckout & ~fifo;
  wire [7:0] tx_word = txq[tx_rd_q];
  wire tx_par   = ^tx_word ^ mode0_q[`SCC_M0_PARODD];
  wire tx_ninth = mode0_q[`SCC_M0_NINE] ? ctrl_q[`SCC_CTRL_TX9] : tx_par;
  wire [AW-1:0] tx_wi = tx_rd_q + tx_cnt_q[AW-1:0];

  wire tx_hit = tx_chk_q & (tfc_q[3] ? (tx_cnt_q <= tfc_q[AW:0])
                                     : (tx_cnt_q == tfc_q[AW:0]));
  wire tx_ev  = (dbl & tx_load)
              | (sgl & tx_adv_u & tx_busy_q & (tx_bits_q == 4'h1))
              | (sgl & tx_fin_i)
              | tx_hit;

  // Receive path.
  wire rx_start = uart & rx_en & ~rx_busy_q & rxd_prev_q & ~rxd_s;
  wire rx_mid   = uart & rx_busy_q & tick & (rx_cnt16_q == `SCC_MID_BIT);
  wire [3:0] rx_stop_ix = extra ? 4'hA : 4'h9;
  wire rx_par_s = rx_mid & (rx_bit_q == 4'h9) & extra;
  wire rx_stop  = rx_mid & (rx_bit_q == rx_stop_ix);
  wire rx_io    = io_edge & rx_en;
  wire rx_fin   = rx_stop | (rx_io & (rx_bit_q == 4'h7));
  wire [7:0] rx_word = uart ? rx_sh_q[8:1] : {rxd_s, rx_sh_q[8:2]};
  wire rx_room  = (rx_cnt_q != cap) | rx_pop;
  wire rx_hold  = rx_fin & ~rx_room & io & mode2_q[`SCC_M2_DBL] & ~fifo & ~rx_pend_q;
  wire rx_ovr   = rx_fin & ~rx_room & ~rx_hold & ~(io & ckout);
  wire rx_fpush = rx_fin & rx_room;
  wire rx_mv    = rx_pop & rx_pend_q & ~fifo & ~rx_fpush;
  wire rx_push  = rx_fpush | rx_mv;
  wire [7:0] rx_pw = rx_mv ? rx_pend_w_q : rx_word;
  wire [AW-1:0] rx_wi = rx_rd_q + rx_cnt_q[AW-1:0];
  wire rx_par_err = rx_par_s & ~mode0_q[`SCC_M0_NINE]
                  & (rxd_s != (^rx_sh_q[8:1] ^ mode0_q[`SCC_M0_PARODD]));
  wire rx_hit = rx_chk_q & (rfc_q[3] ? (rx_cnt_q >= rfc_q[AW:0])
                                     : (rx_cnt_q == rfc_q[AW:0]));
  wire rx_ev  = (~fifo & rx_push) | rx_hit;

  // Bus answer: acknowledge one cycle after the request, data registered.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      wb_ack_o <= acc;
      if (rd) begin
        case (wb_adr_i)
          `SCC_OFS_DATA:  wb_dat_o <= {24'h00_0000, rxq[rx_rd_q]};
          `SCC_OFS_CTRL:  wb_dat_o <= {24'h00_0000, ctrl_q[7:4], rx9_q, frm_q, par_q, ovr_q};
          `SCC_OFS_MODE0: wb_dat_o <= {24'h00_0000, mode0_q};
          `SCC_OFS_MODE1: wb_dat_o <= {31'h0000_0000, tx_en_q};
          `SCC_OFS_MODE2: wb_dat_o <= {25'h000_0000, tx_busy_q,
                                      rx_cnt_q != {(AW+1){1'b0}},
                                      tx_cnt_q == {(AW+1){1'b0}}, 2'h0, mode2_q[1:0]};
          `SCC_OFS_RFC:   wb_dat_o <= {24'h00_0000, rfc_q};
          `SCC_OFS_TFC:   wb_dat_o <= {24'h00_0000, tfc_q};
          `SCC_OFS_DMA:   wb_dat_o <= {24'h00_0000, dma_q};
          default:        wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Settings, kept across a soft reset except the receive and transmit enables, which it clears.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q   <= `SCC_REG_RST;
      mode0_q  <= `SCC_REG_RST;
      mode2_q  <= `SCC_REG_RST;
      rfc_q    <= `SCC_REG_RST;
      tfc_q    <= `SCC_REG_RST;
      dma_q    <= `SCC_REG_RST;
      tx_en_q  <= 1'b0;
      sw_arm_q <= 1'b0;
    end else if (ce) begin
      if (wr & a_ctrl)
        ctrl_q <= {1'b0, wd[6:4], 4'h0};
      if (wr & (wb_adr_i == `SCC_OFS_MODE0))
        mode0_q <= {2'h0, wd[5:0]};
      else if (swr)
        mode0_q[`SCC_M0_RXEN] <= 1'b0;
      if (wr & (wb_adr_i == `SCC_OFS_MODE1))
        tx_en_q <= wd[0];
      else if (swr)
        tx_en_q <= 1'b0;
      if (wr & a_m2) begin
        mode2_q  <= {6'h00, wd[1:0]};
        sw_arm_q <= (wd[3:2] == `SCC_SOFT_RESET_FIELD_FIRST);
      end
      if (wr & (wb_adr_i == `SCC_OFS_RFC))
        rfc_q <= {4'h0, wd[3:0]};
      if (wr & (wb_adr_i == `SCC_OFS_TFC))
        tfc_q <= {4'h0, wd[3:0]};
      if (wr & (wb_adr_i == `SCC_OFS_DMA))
        dma_q <= {6'h00, wd[1:0]};
    end
  end

  // Channel state; a soft reset clears the queues, the shifter control and the ovr, par and frm flags, not the bit clock or rx9_q.
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sclk_prev_q <= 1'b1;
      rxd_prev_q  <= 1'b1;
      div_q       <= 8'h00;
      tx_cnt16_q  <= 4'h0;
      rx_cnt16_q  <= 4'h0;
      tx_rd_q     <= {AW{1'b0}};
      rx_rd_q     <= {AW{1'b0}};
      tx_cnt_q    <= {(AW+1){1'b0}};
      rx_cnt_q    <= {(AW+1){1'b0}};
      tx_sh_q     <= 11'h7FF;
      tx_bits_q   <= 4'h0;
      tx_full_q   <= 1'b0;
      tx_busy_q   <= 1'b0;
      tx_sent_q   <= 1'b0;
      rx_sh_q     <= 9'h000;
      rx_bit_q    <= 4'h0;
      rx_busy_q   <= 1'b0;
      rx_pend_q   <= 1'b0;
      rx_pend_w_q <= 8'h00;
      ovr_q       <= 1'b0;
      par_q       <= 1'b0;
      frm_q       <= 1'b0;
      rx9_q       <= 1'b0;
      tx_chk_q    <= 1'b0;
      rx_chk_q    <= 1'b0;
      txd         <= 1'b1;
      tx_irq      <= 1'b0;
      rx_irq      <= 1'b0;
      tx_dma_req  <= 1'b0;
      rx_dma_req  <= 1'b0;
    end else if (ce) begin
      sclk_prev_q <= sclk_s;
      rxd_prev_q  <= rxd_s;
      div_q       <= tick ? 8'h00 : div_q + 8'h01;
      if (tick)
        tx_cnt16_q <= tx_cnt16_q + 4'h1;
      tx_irq     <= tx_ev & ~swr;
      rx_irq     <= rx_ev & ~swr;
      tx_dma_req <= tx_ev & ~swr & dma_q[1];
      rx_dma_req <= rx_ev & ~swr & dma_q[0];
      tx_chk_q   <= fifo & (tx_push | tx_fin);
      rx_chk_q   <= fifo & (rx_fpush | rx_pop);
      // Flags: a set in the cycle of a clearing read wins.
      ovr_q <= rx_ovr | (ovr_q & ~flg_clr);
      par_q <= rx_par_err | tx_und | (par_q & ~flg_clr);
      frm_q <= (rx_stop & ~rxd_s) | (frm_q & ~flg_clr);
      if (rx_par_s)
        rx9_q <= rxd_s;
      // Transmit queue; a non-empty count means the buffer holds a word.
      if (tx_push)
        txq[tx_wi] <= wd;
      if (tx_load)
        tx_rd_q <= tx_rd_q + {{(AW-1){1'b0}}, 1'b1};
      tx_cnt_q <= tx_cnt_q + (tx_push ? ONE : {(AW+1){1'b0}})
                           - (tx_load ? ONE : {(AW+1){1'b0}});
      if (tx_load) begin
        tx_full_q <= 1'b1;
        tx_sh_q   <= uart ? (extra ? {1'b1, tx_ninth, tx_word, 1'b0}
                                   : {2'h3, tx_word, 1'b0})
                          : {3'h7, tx_word};
        tx_bits_q <= uart ? (extra ? `SCC_UART_BITS + 4'h1 : `SCC_UART_BITS)
                          : `SCC_IO_BITS;
      end else if (tx_fin_u) begin
        tx_busy_q <= 1'b0;
        tx_full_q <= 1'b0;
        txd       <= 1'b1;
      end else if (tx_adv_u | tx_adv_i) begin
        txd       <= tx_sh_q[0];
        tx_sh_q   <= {1'b1, tx_sh_q[10:1]};
        tx_bits_q <= tx_bits_q - 4'h1;
        tx_busy_q <= ~tx_fin_i;
        tx_full_q <= ~tx_fin_i;
        tx_sent_q <= 1'b1;
      end else if (tx_und) begin
        txd <= 1'b1;
      end
      // Receive shifter, UART framing sampled at the bit middle.
      if (rx_start) begin
        rx_busy_q  <= 1'b1;
        rx_cnt16_q <= 4'h0;
        rx_bit_q   <= 4'h0;
      end else if (rx_busy_q & tick) begin
        rx_cnt16_q <= rx_cnt16_q + 4'h1;
        if (rx_mid) begin
          rx_bit_q <= rx_bit_q + 4'h1;
          if ((rx_bit_q == 4'h0) & rxd_s)
            rx_busy_q <= 1'b0;
          if ((rx_bit_q != 4'h0) & (rx_bit_q < 4'h9))
            rx_sh_q <= {rxd_s, rx_sh_q[8:1]};
          if (rx_stop)
            rx_busy_q <= 1'b0;
        end
      end else if (rx_io) begin
        rx_sh_q  <= {rxd_s, rx_sh_q[8:1]};
        rx_bit_q <= (rx_bit_q == 4'h7) ? 4'h0 : rx_bit_q + 4'h1;
      end
      if (uart & rx_stop)
        rx_sh_q <= {1'b0, rx_sh_q[8:1]};
      // Receive queue and the pending word of clocked double buffering.
      if (rx_push)
        rxq[rx_wi] <= rx_pw;
      if (rx_pop)
        rx_rd_q <= rx_rd_q + {{(AW-1){1'b0}}, 1'b1};
      rx_cnt_q <= rx_cnt_q + (rx_push ? ONE : {(AW+1){1'b0}})
                           - (rx_pop ? ONE : {(AW+1){1'b0}});
      if (rx_hold) begin
        rx_pend_q   <= 1'b1;
        rx_pend_w_q <= rx_word;
      end else if (rx_mv) begin
        rx_pend_q <= 1'b0;
      end
      if (swr) begin
        tx_rd_q   <= {AW{1'b0}};
        rx_rd_q   <= {AW{1'b0}};
        tx_cnt_q  <= {(AW+1){1'b0}};
        rx_cnt_q  <= {(AW+1){1'b0}};
        tx_full_q <= 1'b0;
        tx_busy_q <= 1'b0;
        tx_sent_q <= 1'b0;
        tx_bits_q <= 4'h0;
        rx_busy_q <= 1'b0;
        rx_bit_q  <= 4'h0;
        rx_pend_q <= 1'b0;
        ovr_q     <= 1'b0;
        par_q     <= 1'b0;
        frm_q     <= 1'b0;
        tx_chk_q  <= 1'b0;
        rx_chk_q  <= 1'b0;
        txd       <= 1'b1;
      end
    end
  end
endmodule // scc_channel

// file: logic/scc_defines.vh
/*
  Register offsets, field positions, reset values and timing counts of the
  serial channel. Assumes a byte address on the bus, each register one word.
*/
`ifndef SCC_DEFINES_VH
`define SCC_DEFINES_VH

`define SCC_OFS_DATA     8'h00
`define SCC_OFS_CTRL     8'h04
`define SCC_OFS_MODE0    8'h08
`define SCC_OFS_MODE1    8'h0C
`define SCC_OFS_MODE2    8'h10
`define SCC_OFS_RFC      8'h14
`define SCC_OFS_TFC      8'h18
`define SCC_OFS_DMA      8'h1C

`define SCC_CTRL_OVR     0
`define SCC_CTRL_PAR     1
`define SCC_CTRL_FRM     2
`define SCC_CTRL_RX9     3
`define SCC_CTRL_EDGE    4
`define SCC_CTRL_CKOUT   5
`define SCC_CTRL_TX9     6

`define SCC_M0_RXEN      0
`define SCC_M0_FLOW      1
`define SCC_M0_IO        2
`define SCC_M0_NINE      3
`define SCC_M0_PAREN     4
`define SCC_M0_PARODD    5

`define SCC_M2_DBL       0
`define SCC_M2_FIFO      1
`define SCC_M2_TBE       4
`define SCC_M2_RBF       5
`define SCC_M2_TX_RUNNING     6

`define SCC_SOFT_RESET_FIELD_FIRST  2'h2
`define SCC_SOFT_RESET_FIELD_SECOND 2'h1
`define SCC_REG_RST      8'h00
`define SCC_TBC_LAST     4'hF
`define SCC_MID_BIT      4'h7
`define SCC_UART_BITS    4'hA
`define SCC_IO_BITS      4'h8

`endif

// file: logic/scc_sync.v
/*
  Two-flop synchroniser for a group of pins.
  Assumes the inputs are asynchronous to mclk and are single-bit levels.
*/
`timescale 1ns/1ns
module scc_sync #(
  parameter W = 3
) (
  input  wire         mclk,  // System clock.
  input  wire         rstn,  // Asynchronous reset, active low.
  input  wire         ce,    // Clock enable.
  input  wire [W-1:0] d,     // Asynchronous inputs.
  output reg  [W-1:0] q      // Synchronised outputs.
);
  reg [W-1:0] meta_q;

  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= {W{1'b1}};
      q      <= {W{1'b1}};
    end else if (ce) begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule // scc_sync

// file: verification/scc_chk.sv
/*
  Port-level assertions for scc_channel.
  Assumes write data is held through ack and ce stays high.
*/
`timescale 1ns/1ns
`include "scc_defines.vh"
module scc_chk #(
  parameter [7:0] DIV = 8'h04  // Serial tick divider.
) (
  input wire        mclk,        // Clock.
  input wire        rstn,        // Reset, active low.
  input wire        wb_cyc_i,    // Bus cycle.
  input wire        wb_stb_i,    // Bus strobe.
  input wire        wb_we_i,     // Bus write.
  input wire [7:0]  wb_adr_i,    // Bus address.
  input wire [31:0] wb_dat_i,    // Bus write data.
  input wire        wb_ack_o,    // Bus acknowledge.
  input wire        cts_n,       // Clear to send.
  input wire        txd,         // Serial out.
  input wire        rx_irq,      // Receive interrupt.
  input wire        tx_irq,      // Transmit interrupt.
  input wire        rx_dma_req,  // Receive DMA request.
  input wire        tx_dma_req   // Transmit DMA request.
);
  // The gap counter wraps at 1024, exact while the bit length divides it.
  localparam [9:0] BIT_LEN = 16 * DIV;
  wire       wr_ok = wb_ack_o & wb_we_i;
  reg  [1:0] dma_q;
  reg        flow_q, io_q, seen_q, txd_q;
  reg  [9:0] gap_q, cts_q;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      {dma_q, flow_q, io_q, seen_q} <= 5'h00;
      {txd_q, gap_q, cts_q} <= {1'b1, 20'h00000};
    end else begin
      txd_q <= txd;
      gap_q <= (txd != txd_q) ? 10'h000 : gap_q + 10'h001;
      cts_q <= !cts_n ? 10'h000 : (cts_q == 10'h3FF) ? cts_q : cts_q + 10'h001;
      if (wr_ok && wb_adr_i == `SCC_OFS_DMA)
        dma_q <= wb_dat_i[1:0];
      if (wr_ok && wb_adr_i == `SCC_OFS_MODE0)
        {io_q, flow_q} <= wb_dat_i[2:1];
      // Mode writes may cut a frame short or move txd to the shift clock, so phase tracking restarts.
      if (wr_ok && wb_adr_i >= `SCC_OFS_MODE0 && wb_adr_i <= `SCC_OFS_MODE2)
        seen_q <= 1'b0;
      else if (txd != txd_q)
        seen_q <= 1'b1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack_once;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_NEXT: assert property (s_req |=> s_ack_once)
    else $error("ack not a single cycle after request");
  AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  AST_RX_PULSE: assert property (rx_irq |=> !rx_irq)
    else $error("receive interrupt longer than one cycle");
  AST_TX_PULSE: assert property (tx_irq |=> !tx_irq)
    else $error("transmit interrupt longer than one cycle");
  AST_RX_DMA: assert property (rx_dma_req == (rx_irq && dma_q[0]))
    else $error("receive DMA request not with interrupt");
  AST_TX_DMA: assert property (tx_dma_req == (tx_irq && dma_q[1]))
    else $error("transmit DMA request not with interrupt");
  AST_CTS_HOLD: assert property (flow_q && cts_q >= 10'h320 |-> !(txd_q && !txd))
    else $error("frame started while held");
  AST_BIT_TIME: assert property (seen_q && !io_q && txd != txd_q |-> ((gap_q + 10'h001) % BIT_LEN) == 10'h000)
    else $error("serial edge off the bit clock");
endmodule // scc_chk
bind scc_channel scc_chk #(.DIV(DIV)) u_chk (.mclk, .rstn, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_i, .wb_ack_o, .cts_n, .txd, .rx_irq, .tx_irq, .rx_dma_req, .tx_dma_req);

// file: verification/scc_remote.sv
/*
  Remote serial party: sends UART and clocked frames, takes UART frames.
  Assumes it runs on the bench's mclk edges and the data line is pulled up.
*/
`timescale 1ns/1ns
module scc_remote #(
  parameter integer BIT = 64  // Bit time in mclk cycles.
) (
  input  wire mclk,   // Bench clock.
  input  wire txd,    // Device serial output.
  output reg  rxd,    // Device serial input.
  output reg  cts_n,  // Clear to send, active low.
  output reg  sclk    // Shift clock, stands high between frames.
);
  reg     [7:0] got;
  integer       got_cnt = 0;
  reg           pause = 1'b0;
  initial {rxd, cts_n, sclk} = 3'h5;
  task send(input [7:0] b, input stop);
    reg [9:0] fr;
    integer   k;
    begin
      fr = {stop, b, 1'b0};
      for (k = 0; k < 10; k = k + 1) begin
        rxd <= fr[k];
        repeat (BIT) @(posedge mclk);
      end
      rxd <= 1'b1;
      repeat (BIT) @(posedge mclk);
    end
  endtask
  // Data changes with the falling edge and is held past the rising one.
  task shift(input [7:0] b);
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        {rxd, sclk} <= {b[k], 1'b0};
        repeat (4) @(posedge mclk);
        sclk <= 1'b1;
        repeat (4) @(posedge mclk);
      end
      rxd <= 1'b1;
    end
  endtask
  always begin : rx_mon
    reg [7:0] sh;
    integer   k;
    @(negedge txd);
    repeat (BIT / 2) @(posedge mclk);
    for (k = 0; k < 8; k = k + 1) begin
      repeat (BIT) @(posedge mclk);
      sh = {txd, sh[7:1]};
    end
    repeat (BIT) @(posedge mclk);
    got = sh;
    got_cnt = got_cnt + 1;
    if (pause)
      cts_n <= 1'b1;
  end
endmodule // scc_remote

// file: verification/tb_top.sv
/*
  Self-checking bench for scc_channel over its bus and serial pins.
  Assumes the checker binds itself and the remote runs on mclk.
*/
`timescale 1ns/1ns
`include "scc_defines.vh"
module tb_top;
  localparam [7:0] DIV = 8'h04;
  reg         mclk, rstn, cyc, we;
  reg  [7:0]  adr;
  reg  [31:0] wdat, rv;
  wire [31:0] rdat;
  wire        ack, rxd, cts_n, sclk, txd, rx_irq, tx_irq, rx_dma, tx_dma;
  integer     fail_count, check_count, cycles, n_rx, n_tx, n_rd, n_td, nb;
  scc_channel #(.AW(2), .DIV(DIV)) DUT (.mclk(mclk), .rstn(rstn), .ce(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .rxd(rxd), .cts_n(cts_n), .sclk(sclk), .txd(txd),
    .rx_irq(rx_irq), .tx_irq(tx_irq), .rx_dma_req(rx_dma), .tx_dma_req(tx_dma));
  scc_remote #(.BIT(16 * DIV)) u_rem (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n),
    .sclk(sclk));
  always #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles = cycles + 1;
    n_rx = n_rx + (rx_irq === 1'b1);
    n_tx = n_tx + (tx_irq === 1'b1);
    n_rd = n_rd + (rx_dma === 1'b1);
    n_td = n_td + (tx_dma === 1'b1);
    if (cycles == 25000) begin
      fail_count = fail_count + 1;
      test_done;
    end
  end
  task test_done;
    begin
      $display("checks %0d failures %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge mclk);
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      t = 0;
      @(posedge mclk);
      {cyc, we, adr, wdat} <= {1'b1, w, a, d};
      @(posedge mclk);
      while (ack !== 1'b1 && t < 50) begin
        @(posedge mclk);
        t = t + 1;
      end
      rv = rdat;
      cyc <= 1'b0;
      chk(t < 50, 1);
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task wait_rx(input integer n);
    integer t;
    begin
      for (t = 0; u_rem.got_cnt < n && t < 800; t = t + 1)
        @(posedge mclk);
      chk(u_rem.got_cnt, n);
    end
  endtask
  initial begin
    {mclk, rstn, cyc, we, adr, wdat} = 44'h0;
    {fail_count, check_count, cycles, n_rx, n_tx, n_rd, n_td} = 224'h0;
    wt(12);
    rstn <= 1'b1;
    rd(`SCC_OFS_MODE0);
    chk(rv, 32'h0);
    wr(8'h40, 32'hFF);
    rd(8'h40);
    chk(rv, 32'h0);
    wr(`SCC_OFS_MODE1, 32'h1);
    wr(`SCC_OFS_MODE2, 32'h1);
    wr(`SCC_OFS_DMA, 32'h3);
    wr(`SCC_OFS_DATA, 32'hA5);
    wt(4);
    chk(n_tx, 1);
    chk(n_td, 1);
    rd(`SCC_OFS_MODE2);
    chk(rv & 32'h10, 32'h10);
    wait_rx(1);
    chk(u_rem.got, 32'hA5);
    wr(`SCC_OFS_MODE0, 32'h2);
    u_rem.pause = 1'b1;
    wr(`SCC_OFS_DATA, 32'h3C);
    wait_rx(2);
    wr(`SCC_OFS_DATA, 32'hC3);
    wt(100);
    chk(n_tx, 3);
    wt(1000);
    chk(u_rem.got_cnt, 2);
    u_rem.pause = 1'b0;
    u_rem.cts_n <= 1'b0;
    wait_rx(3);
    chk(u_rem.got, 32'hC3);
    wr(`SCC_OFS_MODE0, 32'h1);
    u_rem.send(8'h5A, 1'b1);
    chk(n_rx, 1);
    chk(n_rd, 1);
    rd(`SCC_OFS_DATA);
    chk(rv, 32'h5A);
    u_rem.send(8'h11, 1'b1);
    u_rem.send(8'h22, 1'b1);
    chk(n_rx, 2);
    rd(`SCC_OFS_CTRL);
    chk(rv & 32'h7, 32'h1);
    rd(`SCC_OFS_DATA);
    chk(rv, 32'h11);
    u_rem.send(8'hF0, 1'b0);
    wr(`SCC_OFS_MODE0, 32'h3);
    wr(`SCC_OFS_MODE2, 32'h5);
    rd(`SCC_OFS_MODE0);
    chk(rv, 32'h3);
    wr(`SCC_OFS_MODE2, 32'h9);
    wr(`SCC_OFS_MODE2, 32'h5);
    rd(`SCC_OFS_MODE0);
    chk(rv, 32'h2);
    rd(`SCC_OFS_CTRL);
    chk(rv & 32'h7, 32'h0);
    rd(`SCC_OFS_MODE1);
    chk(rv, 32'h0);
    wr(`SCC_OFS_MODE0, 32'h1);
    wr(`SCC_OFS_MODE2, 32'h2);
    wr(`SCC_OFS_RFC, 32'h2);
    nb = n_rx;
    repeat (3) u_rem.send(8'h01, 1'b1);
    chk(n_rx - nb, 1);
    wr(`SCC_OFS_RFC, 32'hA);
    rd(`SCC_OFS_DATA);
    wt(2);
    chk(n_rx - nb, 2);
    wr(`SCC_OFS_MODE2, 32'h8);
    wr(`SCC_OFS_MODE2, 32'h4);
    wr(`SCC_OFS_CTRL, 32'h10);
    wr(`SCC_OFS_MODE0, 32'h5);
    nb = n_rx;
    u_rem.shift(8'h96);
    wt(8);
    chk(n_rx - nb, 1);
    rd(`SCC_OFS_DATA);
    chk(rv, 32'h96);
    wr(`SCC_OFS_MODE1, 32'h1);
    wr(`SCC_OFS_DATA, 32'h5A);
    nb = n_tx;
    u_rem.shift(8'hFF);
    wt(8);
    chk(n_tx - nb, 1);
    u_rem.shift(8'hFF);
    rd(`SCC_OFS_CTRL);
    chk(rv & 32'h3, 32'h3);
    test_done;
  end
endmodule // tb_top
